// >>> rtl/flash_prot_pkg.sv
`default_nettype none
package flash_prot_pkg;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam int SR_READY_BIT = 7;
  localparam int SR_ERASE_ERR_BIT = 5;
  localparam int SR_PROG_ERR_BIT = 4;
  localparam int SR_SUPPLY_FAULT_BIT = 3;
  localparam int SR_LOCK_FAULT_BIT = 1;
  // Controller registers, byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_WDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  localparam int CTRL_WP_BIT = 0;
  localparam int CTRL_RESET_BIT = 1;
  localparam int CTRL_VPP_BIT = 2;
  localparam logic [2:0] CTRL_RESET_VAL = 3'h0;
  localparam int CMD_OP_LSB = 8;
  localparam logic [1:0] OP_WRITE1 = 2'h0;
  localparam logic [1:0] OP_WRITE2 = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_STATUS_POLL = 2'h3;
  localparam int CLK_PERIOD_NS = 25;
  localparam int RECOVERY_NS = 150;
  localparam int RECOVERY_CYC = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_CYC = 4;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b010,
    ST_HOLD  = 3'b011,
    ST_DONE  = 3'b100
  } bus_state_t;
endpackage
`default_nettype wire

// >>> rtl/flash_cycle_timer.sv
`default_nettype none
module flash_cycle_timer #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] count_i,
  output logic                  zero_o
);
  logic [WIDTH-1:0] remain;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      remain <= '0;
    end else if (load_i) begin
      remain <= count_i;
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end
  end
  assign zero_o = (remain == '0);
endmodule
`default_nettype wire

// >>> rtl/flash_prot_host.sv
// The APB register port and the placing of the registers are this design's own decisions.
`default_nettype none
module flash_prot_host #(
  parameter int AW = 22,
  parameter int DW = 16
) (
  input  wire logic          ref_clk_i,
  input  wire logic          arst_n_i,
  input  wire logic          psel_i,
  input  wire logic          penable_i,
  input  wire logic          pwrite_i,
  input  wire logic [7:0]    paddr_i,
  input  wire logic [31:0]   pwdata_i,
  output logic [31:0]        prdata_o,
  output logic               pready_o,
  output logic               pslverr_o,
  output logic [AW-1:0]      flash_addr_o,
  input  wire logic [DW-1:0] flash_dq_i,
  output logic [DW-1:0]      flash_dq_o,
  output logic               flash_dq_oe_o,
  output logic               chip_select_n_o,
  output logic               output_enable_n_o,
  output logic               write_strobe_n_o,
  output logic               write_protect_n_o,
  output logic               reset_powerdown_n_o,
  output logic               program_supply_en_o
);
  import flash_prot_pkg::*;

  bus_state_t       state;
  bus_state_t       next_state;
  logic [2:0]       ctrl;
  logic [AW-1:0]    addr;
  logic [DW-1:0]    wdata;
  logic [DW-1:0]    rdata;
  logic [7:0]       last_sr;
  logic [1:0]       op;
  logic             busy;
  logic             pending_confirm;
  logic             need_read_array;
  logic             recovery_done;
  logic             timer_zero;
  logic             timer_load;
  logic [7:0]       timer_count;
  logic             rst_prev;

  wire access   = psel_i && penable_i;
  wire wr_ctrl  = access && pwrite_i && (paddr_i == REG_CTRL);
  wire wr_cmd   = access && pwrite_i && (paddr_i == REG_CMD);
  wire wr_addr  = access && pwrite_i && (paddr_i == REG_ADDR);
  wire wr_wdata = access && pwrite_i && (paddr_i == REG_WDATA);
  wire mapped   = (paddr_i == REG_CTRL) || (paddr_i == REG_CMD) || (paddr_i == REG_ADDR) ||
                  (paddr_i == REG_WDATA) || (paddr_i == REG_STATUS) || (paddr_i == REG_RDATA);
  wire in_reset = !ctrl[CTRL_RESET_BIT];
  // Bus cycles refused while reset held or still recovering
  wire start_ok = wr_cmd && !busy && !in_reset && recovery_done;
  wire [1:0] cmd_op = pwdata_i[CMD_OP_LSB +: 2];
  wire is_write = (op == OP_WRITE1) || (op == OP_WRITE2);

  assign pready_o  = 1'b1;
  assign pslverr_o = access && (!mapped || (wr_cmd && !start_ok));

  always_comb begin
    prdata_o = 32'h0;
    case (paddr_i)
      REG_CTRL:   prdata_o = {29'h0, ctrl};
      REG_ADDR:   prdata_o = {{(32-AW){1'b0}}, addr};
      REG_WDATA:  prdata_o = {{(32-DW){1'b0}}, wdata};
      REG_STATUS: prdata_o = {20'h0, need_read_array, pending_confirm, recovery_done, busy, last_sr};
      REG_RDATA:  prdata_o = {{(32-DW){1'b0}}, rdata};
      default:    prdata_o = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl  <= CTRL_RESET_VAL;
      addr  <= '0;
      wdata <= '0;
    end else begin
      if (wr_ctrl) ctrl <= pwdata_i[2:0];
      if (wr_addr) addr <= pwdata_i[AW-1:0];
      if (wr_wdata) wdata <= pwdata_i[DW-1:0];
    end
  end

  // Recovery timer reloads on every rising reset edge
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) rst_prev <= 1'b0;
    else rst_prev <= ctrl[CTRL_RESET_BIT];
  end
  wire rst_rise = ctrl[CTRL_RESET_BIT] && !rst_prev;

  always_comb begin
    timer_load  = 1'b0;
    timer_count = 8'h00;
    if (rst_rise) begin
      timer_load  = 1'b1;
      timer_count = 8'(RECOVERY_CYC);
    end else if (state == ST_IDLE && start_ok) begin
      timer_load  = 1'b1;
      timer_count = 8'(BUS_CYC);
    end
  end

  flash_cycle_timer #(.WIDTH(8)) u_timer (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .load_i    (timer_load),
    .count_i   (timer_count),
    .zero_o    (timer_zero)
  );

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) recovery_done <= 1'b0;
    else if (in_reset || rst_rise) recovery_done <= 1'b0;
    else if (timer_zero && state == ST_IDLE) recovery_done <= 1'b1;
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:   if (start_ok) next_state = ST_SETUP;
      ST_SETUP:  next_state = ST_STROBE;
      ST_STROBE: if (timer_zero) next_state = ST_HOLD;
      ST_HOLD:   next_state = ST_DONE;
      ST_DONE:   next_state = ST_IDLE;
      default:   next_state = ST_IDLE;
    endcase
    // Pulling reset aborts the cycle at once
    if (in_reset) next_state = ST_IDLE;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_IDLE;
      op    <= OP_READ;
      busy  <= 1'b0;
    end else begin
      state <= next_state;
      if (state == ST_IDLE && start_ok) begin
        op   <= cmd_op;
        busy <= 1'b1;
      end else if (next_state == ST_IDLE) begin
        busy <= 1'b0;
      end
    end
  end

  // Track command sequence so software sees whether a confirm or read-array is owed
  wire cmd_done = (state == ST_DONE);
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pending_confirm <= 1'b0;
      need_read_array <= 1'b0;
    end else if (in_reset) begin
      pending_confirm <= 1'b0;
      need_read_array <= 1'b0;
    end else if (cmd_done && is_write) begin
      pending_confirm <= (op == OP_WRITE1) &&
                         ((wdata[7:0] == CMD_PROGRAM) || (wdata[7:0] == CMD_ERASE));
      if (op == OP_WRITE2 || wdata[7:0] == CMD_READ_STATUS) need_read_array <= 1'b1;
      if (op == OP_WRITE1 && wdata[7:0] == CMD_READ_ARRAY) need_read_array <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata   <= '0;
      last_sr <= 8'h00;
    end else if (in_reset) begin
      last_sr <= 8'h00;
    end else if (state == ST_HOLD && !is_write) begin
      rdata <= flash_dq_i;
      if (op == OP_STATUS_POLL) last_sr <= flash_dq_i[7:0];
    end
  end

  // Op of a cycle being started or running; strobes are launched from next_state
  wire [1:0] next_op       = (state == ST_IDLE && start_ok) ? cmd_op : op;
  wire       next_is_write = (next_op == OP_WRITE1) || (next_op == OP_WRITE2);

  // Strobes only low inside a cycle; idle chip select high means standby
  wire cycle_on = (state == ST_SETUP) || (state == ST_STROBE) || (state == ST_HOLD);
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      chip_select_n_o     <= 1'b1;
      output_enable_n_o   <= 1'b1;
      write_strobe_n_o    <= 1'b1;
      flash_dq_o          <= '0;
      flash_dq_oe_o       <= 1'b0;
      flash_addr_o        <= '0;
      write_protect_n_o   <= 1'b0;
      reset_powerdown_n_o <= 1'b0;
      program_supply_en_o <= 1'b0;
    end else begin
      write_protect_n_o   <= ctrl[CTRL_WP_BIT];
      reset_powerdown_n_o <= ctrl[CTRL_RESET_BIT];
      program_supply_en_o <= ctrl[CTRL_VPP_BIT];
      chip_select_n_o     <= !(next_state == ST_SETUP || next_state == ST_STROBE ||
                               next_state == ST_HOLD);
      output_enable_n_o   <= !((next_state == ST_STROBE || next_state == ST_HOLD) && !next_is_write);
      write_strobe_n_o    <= !(next_state == ST_STROBE && next_is_write);
      flash_dq_oe_o       <= (next_state != ST_IDLE && next_state != ST_DONE) && next_is_write;
      flash_dq_o          <= wdata;
      flash_addr_o        <= addr;
    end
  end
  a_strobe_pair: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    !write_strobe_n_o |-> !chip_select_n_o && output_enable_n_o)
    else $error("write strobe without chip select");
  a_reset_idle: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    !reset_powerdown_n_o |-> chip_select_n_o && write_strobe_n_o)
    else $error("bus active during reset");
  a_recovery_wait: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    $rose(reset_powerdown_n_o) |-> chip_select_n_o [*6])
    else $error("access before recovery time");
  a_status_clear: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    in_reset |=> last_sr == 8'h00)
    else $error("status kept through reset");
  a_abort_cycle: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    in_reset |=> state == ST_IDLE)
    else $error("cycle not aborted");
  a_standby_idle: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    state == ST_IDLE && $past(state) == ST_IDLE |-> chip_select_n_o && !flash_dq_oe_o)
    else $error("idle bus not in standby");
  a_wp_follow: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    ##1 write_protect_n_o == $past(ctrl[CTRL_WP_BIT]))
    else $error("write protect pin lag");
  a_confirm_seq: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    cmd_done && op == OP_WRITE1 && wdata[7:0] == CMD_ERASE && !in_reset |=> pending_confirm)
    else $error("confirm not tracked");
  a_select_window: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    chip_select_n_o == !cycle_on)
    else $error("chip select outside cycle window");
endmodule
`default_nettype wire

// >>> test/flash_dev_model.sv
`default_nettype none
module flash_dev_model #(
  parameter int  TOP_BOOT = 0,
  parameter int  NBLK     = 64,
  parameter real REC_NS   = 150.0
) (
  input  wire logic [21:0] addr_i,
  input  wire logic        cs_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        wp_n_i,
  input  wire logic        pd_n_i,
  input  wire logic        vpp_i,
  input  wire logic [15:0] dq_i,
  output logic      [15:0] dq_o,
  output logic             drive_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [int];
  logic [7:0]  sr;
  logic [1:0]  mode;
  logic        ready;
  logic        lk;
  int          blk;
  wire         wr_n = we_n_i | cs_n_i;
  // Data only after the recovery time has run out
  always @(pd_n_i) begin
    ready = 1'b0;
    if (pd_n_i === 1'b1) #(REC_NS) ready = pd_n_i;
  end
  assign drive_o = !cs_n_i && !oe_n_i && pd_n_i && ready;
  always @(addr_i or mode or sr) begin
    if (mode != 2'h0) dq_o = {8'h00, sr};
    else dq_o = mem.exists(int'(addr_i)) ? mem[int'(addr_i)] : 16'hFFFF;
  end
  always @(posedge wr_n or negedge pd_n_i) begin
    if (pd_n_i !== 1'b1) begin
      sr = 8'h80;
      mode = 2'h0;
    end else if (mode[1]) begin
      blk = int'(addr_i[21:16]);
      lk = (TOP_BOOT != 0) ? (blk >= NBLK - 2) : (blk < 2);
      if (!vpp_i) sr |= 8'h08;
      else if (!wp_n_i && lk) sr |= 8'h02;
      // Operation completes at the strobe, whatever chip select does after
      else if (mode == 2'h2) mem[int'(addr_i)] = dq_i;
      else if (dq_i[7:0] == 8'hD0) begin
        for (int k = blk << 16; k < (blk + 1) << 16; k++) if (mem.exists(k)) mem.delete(k);
      end else sr |= 8'h30;
      mode = 2'h1;
    end else begin
      case (dq_i[7:0])
        8'h40, 8'h10: mode = 2'h2;
        8'h20: mode = 2'h3;
        8'h70: mode = 2'h1;
        8'h50: sr = 8'h80;
        8'hFF: mode = 2'h0;
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> test/flash_write_protect_power_ctrl_bench.sv
`default_nettype none
module flash_write_protect_power_ctrl_bench import flash_prot_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i = 1'b0, arst_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, rerr, dq_oe, cs_n, oe_n, we_n, wp_n, pd_n, vpp, dev_drive;
  logic [21:0] f_addr;
  logic [21:0] fa [3];
  logic [15:0] fd [3];
  logic [15:0] dq_o, dq_i, dev_dq, bus_last = 16'h0;
  int          bad_count = 0, total_checks = 0, cycles = 0, seed = 98392;
  always #12.5 ref_clk_i = ~ref_clk_i;
  // Released bus shows a changing pattern, never a stale value
  assign dq_i = dq_oe ? dq_o : dev_drive ? dev_dq : ~bus_last;
  flash_prot_host #(.AW(22), .DW(16)) u_dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .flash_addr_o(f_addr), .flash_dq_i(dq_i), .flash_dq_o(dq_o),
    .flash_dq_oe_o(dq_oe), .chip_select_n_o(cs_n), .output_enable_n_o(oe_n), .write_strobe_n_o(we_n),
    .write_protect_n_o(wp_n), .reset_powerdown_n_o(pd_n), .program_supply_en_o(vpp));
  flash_dev_model u_flash (.addr_i(f_addr), .cs_n_i(cs_n), .oe_n_i(oe_n), .we_n_i(we_n), .wp_n_i(wp_n),
    .pd_n_i(pd_n), .vpp_i(vpp), .dq_i(dq_i), .dq_o(dev_dq), .drive_o(dev_drive));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    bus_last <= dq_i;
    if (we_n === 1'b0) chk(cs_n, 1'b0);
    if (cycles == 40000) begin
      bad_count++;
      results();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_st(input int b, input logic v);
    for (int i = 0; i < 100; i++) begin
      apb(1'b0, REG_STATUS, 32'h0);
      if (rdat[b] === v) return;
    end
    chk(rdat[b], v);
  endtask
  task automatic fcmd(input logic [1:0] op, input logic [15:0] v);
    apb(1'b1, REG_WDATA, {16'h0, v});
    apb(1'b1, REG_CMD, {22'h0, op, v[7:0]});
    chk(rerr, 1'b0);
    wait_st(8, 1'b0);
  endtask
  task automatic rd(input logic [21:0] a, input logic arr);
    apb(1'b1, REG_ADDR, {10'h0, a});
    if (arr) fcmd(OP_WRITE1, 16'h00FF);
    fcmd(OP_READ, 16'h0);
    apb(1'b0, REG_RDATA, 32'h0);
  endtask
  // Two-cycle sequence, then status is what the array returns
  task automatic op2(input logic [21:0] a, input logic [15:0] v, input logic [7:0] c, input logic [7:0] e);
    fcmd(OP_WRITE1, 16'h0050);
    apb(1'b1, REG_ADDR, {10'h0, a});
    fcmd(OP_WRITE1, {8'h0, c});
    fcmd(OP_WRITE2, (c == 8'h40) ? v : 16'h00D0);
    rd(a, 1'b0);
    chk(rdat[7:0], e);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rdat, 32'h0);
    chk({pd_n, wp_n, vpp}, 3'h0);
    apb(1'b0, 8'h3C, 32'h0);
    chk(rerr, 1'b1);
    chk(rdat, 32'h0);
    $display("test reset done");
    apb(1'b1, REG_CTRL, 32'h7);
    apb(1'b1, REG_CMD, {22'h0, OP_WRITE1, 8'hFF});
    chk(rerr, 1'b1);
    wait_st(9, 1'b1);
    for (int i = 0; i < 3; i++) begin
      fa[i] = 22'($random(seed));
      fa[i][21:16] = 6'(i + 4);
      fd[i] = 16'($random(seed));
      op2(fa[i], fd[i], 8'h40, 8'h80);
    end
    for (int i = 0; i < 3; i++) begin
      rd(fa[i], 1'b1);
      chk(rdat[15:0], fd[i]);
    end
    $display("test program done");
    apb(1'b1, REG_CTRL, 32'h6);
    op2({6'h01, fd[0]}, fd[1], 8'h40, 8'h82);
    op2({6'h00, fd[1]}, 16'h0, 8'h20, 8'h82);
    rd({6'h01, fd[0]}, 1'b1);
    chk(rdat[15:0], 16'hFFFF);
    apb(1'b1, REG_CTRL, 32'h7);
    op2({6'h01, fd[0]}, fd[1], 8'h40, 8'h80);
    op2(fa[0], 16'h0, 8'h20, 8'h80);
    rd(fa[0], 1'b1);
    chk(rdat[15:0], 16'hFFFF);
    apb(1'b1, REG_CTRL, 32'h2);
    op2(fa[2], 16'h0, 8'h40, 8'h88);
    $display("test protect done");
    // Reset pulled while a read cycle is still strobing
    apb(1'b1, REG_CMD, {22'h0, OP_READ, 8'h00});
    apb(1'b1, REG_CTRL, 32'h5);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rdat[11:0], 12'h000);
    apb(1'b1, REG_CMD, {22'h0, OP_WRITE1, 8'h70});
    chk(rerr, 1'b1);
    apb(1'b1, REG_CTRL, 32'h7);
    wait_st(9, 1'b1);
    rd(fa[1], 1'b0);
    chk(rdat[15:0], fd[1]);
    fcmd(OP_WRITE1, 16'h0070);
    rd(fa[1], 1'b0);
    chk(rdat[7:0], 8'h80);
    $display("test powerdown done");
    results();
  end
endmodule
`default_nettype wire
